// File: wiper_log_taper.sv
// command execution, log-taper stepping and nonvolatile word map of the dual wiper
`timescale 1ns/100ps
module wiper_log_taper
  import potentiometer_pkg::*;
#(
  parameter logic [15:0] TOLERANCE_WORD = 16'h8000 // arbitrary factory value
)
(
  // clock, reset, enable
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic                 clkEnable,
  // serial link
  input  wire logic                 sclk,
  input  wire logic                 csN,
  input  wire logic                 sdi,
  output logic                      sdo,
  // restore strobe pin
  input  wire logic                 restoreStrobeN,
  // wiper state
  output logic [TAP_COUNT-1:0]      tapSwitch1,
  output logic [TAP_COUNT-1:0]      tapSwitch2,
  output logic [WIPER_BITS-1:0]     wiper1Value,
  output logic [WIPER_BITS-1:0]     wiper2Value,
  output logic                      readPowerActive,
  // decoded tolerance word
  output logic                      tolerancePositive,
  output logic [6:0]                tolerancePercent,
  output logic [7:0]                toleranceFraction
);

  // ---------------- link domain (sclk) ----------------
  logic [4:0]  bitCnt_reg, bitCnt_next;
  logic [23:0] shiftIn_reg, shiftIn_next;
  logic [23:0] frameWord_reg, frameWord_next;
  logic        anyTgl_reg, anyTgl_next;
  logic        fullTgl_reg, fullTgl_next;
  logic        sdo_reg, sdo_next;
  logic [23:0] outWord_reg, outWord_next;

  always_comb
  begin
    bitCnt_next    = bitCnt_reg;
    shiftIn_next   = {shiftIn_reg[22:0], sdi};
    frameWord_next = frameWord_reg;
    anyTgl_next    = anyTgl_reg;
    fullTgl_next   = fullTgl_reg;
    if (bitCnt_reg <= FRAME_LAST)
      bitCnt_next = bitCnt_reg + 5'h01;
    if (bitCnt_reg == 5'h00)
      anyTgl_next = ~anyTgl_reg;
    if (bitCnt_reg == FRAME_LAST)
    begin
      fullTgl_next   = ~fullTgl_reg;
      frameWord_next = {shiftIn_reg[22:0], sdi};
    end
  end

  // the count clears while chip select is high, since sclk may stand still between frames
  always_ff @(posedge sclk or posedge csN or negedge rst_n)
  begin
    if (!rst_n)
      bitCnt_reg <= 5'h00;
    else if (csN)
      bitCnt_reg <= 5'h00;
    else
      bitCnt_reg <= bitCnt_next;
  end

  always_ff @(posedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shiftIn_reg   <= 24'h000000;
      frameWord_reg <= 24'h000000;
      anyTgl_reg    <= 1'b0;
      fullTgl_reg   <= 1'b0;
    end
    else
    begin
      shiftIn_reg   <= shiftIn_next;
      frameWord_reg <= frameWord_next;
      anyTgl_reg    <= anyTgl_next;
      fullTgl_reg   <= fullTgl_next;
    end
  end

  // outWord only changes just after chip select rises, so it is quiet during a frame
  always_comb
  begin
    sdo_next = 1'b0;
    if (bitCnt_reg != 5'h00 && bitCnt_reg <= FRAME_LAST)
      sdo_next = outWord_reg[FRAME_LAST - bitCnt_reg];
  end

  always_ff @(negedge sclk or negedge rst_n)
  begin
    if (!rst_n)
      sdo_reg <= 1'b0;
    else
      sdo_reg <= sdo_next;
  end

  assign sdo = sdo_reg;

  // ---------------- system domain (ref_clk) ----------------
  logic [3:0] sync1_reg, sync2_reg, sync3_reg, filt_reg, filt_next;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
      filt_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : filt_reg[i];
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_reg <= SYNC_RESET;
      sync2_reg <= SYNC_RESET;
      sync3_reg <= SYNC_RESET;
      filt_reg  <= SYNC_RESET;
    end
    else if (clkEnable)
    begin
      sync1_reg <= {fullTgl_reg, anyTgl_reg, restoreStrobeN, csN};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg  <= filt_next;
    end
  end

  logic        csRise, strobeFall, isRepeat, isNew, doCmd, act;
  logic [23:0] cmdWord;
  logic [3:0]  opcode, addr;
  logic        anySeen_reg, anySeen_next, fullSeen_reg, fullSeen_next;
  logic [23:0] lastCmd_reg, lastCmd_next;

  always_comb
  begin
    csRise     = filt_next[0] & ~filt_reg[0];
    strobeFall = ~filt_next[1] & filt_reg[1];
    isRepeat   = filt_next[2] == anySeen_reg;
    isNew      = filt_next[3] != fullSeen_reg;
    doCmd      = csRise & (isRepeat | isNew);
    cmdWord    = isRepeat ? lastCmd_reg : frameWord_reg;
    opcode     = cmdWord[OPCODE_MSB:OPCODE_LSB];
    addr       = cmdWord[ADDR_MSB:ADDR_LSB];
    anySeen_next  = csRise ? filt_next[2] : anySeen_reg;
    fullSeen_next = csRise ? filt_next[3] : fullSeen_reg;
    lastCmd_next  = (doCmd && !isRepeat) ? frameWord_reg : lastCmd_reg;
  end

  assign act = doCmd & clkEnable;

  logic [9:0]      wiper_reg [CHANNELS];
  logic [9:0]      wiper_next [CHANNELS];
  logic [15:0]     store_reg [STORE_DEPTH];
  logic [15:0]     store_next [STORE_DEPTH];
  power_state_type power_reg, power_next;
  logic [6:0]      tolInt_reg;
  logic [7:0]      tolFrac_reg;
  logic            tolSign_reg;

  always_comb
  begin
    logic sel;
    sel = 1'b0;
    wiper_next   = wiper_reg;
    store_next   = store_reg;
    power_next   = power_reg;
    outWord_next = outWord_reg;
    if (doCmd)
    begin
      outWord_next = {8'h00, cmdWord[DATA_MSB:0]};
      for (int ch = 0; ch < CHANNELS; ch++)
      begin
        sel = (cmdWord[CHANNEL_SELECT_BIT] == ch[0]);
        unique case (opcode)
          OP_RESTORE_ONE: if (sel) wiper_next[ch] = store_reg[ch][9:0];
          OP_SAVE_WIPER:  if (sel) store_next[ch] = {6'h00, wiper_reg[ch]};
          OP_SHR_ONE:     if (sel) wiper_next[ch] = shrLog(wiper_reg[ch]);
          OP_SHR_ALL:     wiper_next[ch] = shrLog(wiper_reg[ch]);
          OP_RESTORE_ALL: wiper_next[ch] = store_reg[ch][9:0];
          OP_WRITE_WIPER: if (sel) wiper_next[ch] = cmdWord[9:0];
          OP_SHL_ONE:     if (sel) wiper_next[ch] = shlLog(wiper_reg[ch]);
          OP_SHL_ALL:     wiper_next[ch] = shlLog(wiper_reg[ch]);
          default:        ;
        endcase
      end
      // step opcodes above never look at the data bytes
      if (opcode == OP_STORE_WORD && addr != END_TO_END_TOLERANCE)
        store_next[addr] = cmdWord[DATA_MSB:0];
      if (opcode == OP_READ_STORE)
        outWord_next = {8'h00, store_reg[addr]};
      if (opcode == OP_READ_WIPER)
        outWord_next = {14'h0000, wiper_reg[addr[0]]};
      if (opcode == OP_RESTORE_ONE)
        power_next = POWER_READ;
      if (opcode == OP_NOP)
        power_next = POWER_IDLE;
    end
    // the pin strobe wins when it lands on the same cycle as a command
    if (strobeFall)
      for (int ch = 0; ch < CHANNELS; ch++)
        wiper_next[ch] = store_reg[ch][9:0];
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      anySeen_reg  <= 1'b0;
      fullSeen_reg <= 1'b0;
      lastCmd_reg  <= LAST_CMD_RESET;
      power_reg    <= POWER_IDLE;
      outWord_reg  <= 24'h000000;
      // power-on state equals the stored wiper words
      for (int ch = 0; ch < CHANNELS; ch++)
        wiper_reg[ch] <= STORE_WIPER_RESET[9:0];
      for (int a = 0; a < STORE_DEPTH; a++)
        store_reg[a] <= (a < 2) ? STORE_WIPER_RESET : STORE_GENERAL_RESET;
      store_reg[END_TO_END_TOLERANCE] <= TOLERANCE_WORD;
    end
    else if (clkEnable)
    begin
      anySeen_reg  <= anySeen_next;
      fullSeen_reg <= fullSeen_next;
      lastCmd_reg  <= lastCmd_next;
      power_reg    <= power_next;
      outWord_reg  <= outWord_next;
      wiper_reg    <= wiper_next;
      store_reg    <= store_next;
    end
  end

  // tolerance fields are registered so the outputs come from flip-flops
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tolSign_reg <= 1'b0;
      tolInt_reg  <= 7'h00;
      tolFrac_reg <= 8'h00;
    end
    else if (clkEnable)
    begin
      tolSign_reg <= store_reg[END_TO_END_TOLERANCE][TOL_SIGN_BIT];
      tolInt_reg  <= store_reg[END_TO_END_TOLERANCE][TOL_INT_MSB:TOL_INT_LSB];
      tolFrac_reg <= store_reg[END_TO_END_TOLERANCE][TOL_FRAC_MSB:0];
    end
  end

  assign tolerancePositive = tolSign_reg;
  assign tolerancePercent  = tolInt_reg;
  assign toleranceFraction = tolFrac_reg;
  assign wiper1Value       = wiper_reg[0];
  assign wiper2Value       = wiper_reg[1];
  assign readPowerActive   = (power_reg == POWER_READ);

  wiper_tap_decoder decodeOne (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .clkEnable (clkEnable),
    .wiperCode (wiper_reg[0]),
    .tapSwitch (tapSwitch1)
  );

  wiper_tap_decoder decodeTwo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .clkEnable (clkEnable),
    .wiperCode (wiper_reg[1]),
    .tapSwitch (tapSwitch2)
  );

  // ---------------- checks ----------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence upOne;
    act && !strobeFall && opcode == OP_SHL_ONE && !cmdWord[CHANNEL_SELECT_BIT];
  endsequence
  sequence strobeSeen;
    strobeFall && clkEnable;
  endsequence

  shl_zero_a: assert property (upOne and (wiper_reg[0] == WIPER_ZERO) |=> wiper_reg[0] == WIPER_ONE)
    else $error("up step from zero did not load one");
  shl_mid_a: assert property (upOne and (wiper_reg[0] >= WIPER_MID) |=> wiper_reg[0] == WIPER_FULL)
    else $error("up step at midscale did not saturate");
  shl_full_a: assert property (upOne and (wiper_reg[0] == WIPER_FULL) |=> $stable(wiper_reg[0]))
    else $error("full scale moved on up step");
  shr_step_a: assert property (act && !strobeFall && opcode == OP_SHR_ALL
    |=> wiper_reg[1] == {1'b0, $past(wiper_reg[1][9:1])})
    else $error("down step not a right shift");
  gang_up_a: assert property (act && !strobeFall && opcode == OP_SHL_ALL
    |=> wiper_reg[0] == shlLog($past(wiper_reg[0])) && wiper_reg[1] == shlLog($past(wiper_reg[1])))
    else $error("ganged up step wrong on a channel");
  repeat_cmd_a: assert property (act && isRepeat |=> $stable(lastCmd_reg))
    else $error("repeat changed the remembered command");
  new_cmd_a: assert property (act && !isRepeat |=> lastCmd_reg == $past(frameWord_reg))
    else $error("new frame not remembered");
  tol_locked_a: assert property ($stable(store_reg[END_TO_END_TOLERANCE]))
    else $error("tolerance word overwritten");
  exec_edge_a: assert property (!$stable(wiper_reg[0]) |-> $past(act || (strobeFall && clkEnable)))
    else $error("wiper moved outside command execution");
  strobe_restore_a: assert property (strobeSeen |=> wiper_reg[0] == $past(store_reg[0][9:0]))
    else $error("restore strobe did not reload wiper");

endmodule

// File: potentiometer_pkg.sv
// shared constants, opcodes and step functions for the dual wiper command logic
package potentiometer_pkg;

  localparam int WIPER_BITS  = 10;
  localparam int TAP_COUNT   = 1024;
  localparam int WORD_BITS   = 16;
  localparam int STORE_DEPTH = 16;
  localparam int FRAME_BITS  = 24;
  localparam int CHANNELS    = 2;

  // frame field positions
  localparam int OPCODE_MSB  = 23;
  localparam int OPCODE_LSB  = 20;
  localparam int ADDR_MSB    = 19;
  localparam int ADDR_LSB    = 16;
  localparam int DATA_MSB    = 15;
  localparam int CHANNEL_SELECT_BIT = 16;
  localparam logic [4:0] FRAME_LAST = 5'h17;

  // opcodes
  localparam logic [3:0] OP_NOP         = 4'h0;
  localparam logic [3:0] OP_RESTORE_ONE = 4'h1;
  localparam logic [3:0] OP_SAVE_WIPER  = 4'h2;
  localparam logic [3:0] OP_STORE_WORD  = 4'h3;
  localparam logic [3:0] OP_SHR_ONE     = 4'h4;
  localparam logic [3:0] OP_SHR_ALL     = 4'h5;
  localparam logic [3:0] OP_RESTORE_ALL = 4'h8;
  localparam logic [3:0] OP_READ_STORE  = 4'h9;
  localparam logic [3:0] OP_READ_WIPER  = 4'hA;
  localparam logic [3:0] OP_WRITE_WIPER = 4'hB;
  localparam logic [3:0] OP_SHL_ONE     = 4'hC;
  localparam logic [3:0] OP_SHL_ALL     = 4'hD;

  // nonvolatile store map
  localparam logic [3:0] WIPER1_SAVED_SETTING = 4'h0;
  localparam logic [3:0] WIPER2_SAVED_SETTING = 4'h1;
  localparam logic [3:0] GENERAL_WORD_FIRST   = 4'h2;
  localparam logic [3:0] GENERAL_WORD_LAST    = 4'hE;
  localparam logic [3:0] END_TO_END_TOLERANCE = 4'hF;

  // tolerance word fields: sign (1 = positive), integer percent, binary fraction
  localparam int TOL_SIGN_BIT = 15;
  localparam int TOL_INT_MSB  = 14;
  localparam int TOL_INT_LSB  = 8;
  localparam int TOL_FRAC_MSB = 7;

  localparam logic [9:0]  WIPER_ZERO = 10'h000;
  localparam logic [9:0]  WIPER_ONE  = 10'h001;
  localparam logic [9:0]  WIPER_MID  = 10'h200;
  localparam logic [9:0]  WIPER_FULL = 10'h3FF;

  localparam logic [15:0] STORE_WIPER_RESET   = 16'h0200;
  localparam logic [15:0] STORE_GENERAL_RESET = 16'h0000;
  localparam logic [23:0] LAST_CMD_RESET      = 24'h000000;
  // cs, restore strobe, first-bit toggle, full-frame toggle
  localparam logic [3:0]  SYNC_RESET          = 4'h3;

  typedef enum logic {POWER_IDLE = 1'b0, POWER_READ = 1'b1} power_state_type;

  function automatic logic [9:0] shlLog(input logic [9:0] v);
    if (v == WIPER_ZERO)
      shlLog = WIPER_ONE;
    else if (v >= WIPER_MID)
      shlLog = WIPER_FULL;
    else
      shlLog = {v[8:0], 1'b0};
  endfunction

  // zero shifts to zero, so the down step stops there without a special case
  function automatic logic [9:0] shrLog(input logic [9:0] v);
    shrLog = {1'b0, v[9:1]};
  endfunction

endpackage

// File: wiper_tap_decoder.sv
// registered one-hot decode of a wiper code onto its tap switches
`timescale 1ns/100ps
module wiper_tap_decoder
  import potentiometer_pkg::*;
#(
  parameter int         TAPS       = TAP_COUNT,
  parameter logic [9:0] RESET_CODE = STORE_WIPER_RESET[9:0]
)
(
  // clock, reset, enable
  input  wire logic            ref_clk,
  input  wire logic            rst_n,
  input  wire logic            clkEnable,
  // code in, switches out
  input  wire logic [9:0]      wiperCode,
  output logic      [TAPS-1:0] tapSwitch
);

  // refused at elaboration: the one-hot decode needs one tap per code
  if (TAPS != (1 << WIPER_BITS))
    $error("tap count must equal two to the wiper width");

  logic [TAPS-1:0] tap_reg;
  logic [TAPS-1:0] tap_next;

  always_comb
  begin
    tap_next = '0;
    tap_next[wiperCode] = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      tap_reg <= TAPS'(1) << RESET_CODE;
    else if (clkEnable)
      tap_reg <= tap_next;
  end

  assign tapSwitch = tap_reg;

  tap_single_a: assert property (@(posedge ref_clk) disable iff (!rst_n) $onehot(tap_reg))
    else $error("tap switches not one-hot");

endmodule

// File: spi_host_model.sv
// serial host model that issues command frames to the wiper block
`timescale 1ns/100ps
module spi_host_model
(
  // serial link
  output logic      sclk,
  output logic      csN,
  output logic      sdi,
  input  wire logic sdo
);
  initial
  begin
    sclk = 1'b0;
    csN  = 1'b1;
    sdi  = 1'b0;
  end

  // clock stands low between frames; sdi flips once released so stale data never looks valid
  task automatic xfer(input logic [23:0] tx, input int nBits, output logic [23:0] rx);
    rx = 24'h000000;
    #7 csN = 1'b0;
    for (int i = 23; i > 23 - nBits; i--)
    begin
      sdi = tx[i];
      #15 sclk = 1'b1;
      rx[i] = sdo;
      #15 sclk = 1'b0;
    end
    #7 csN = 1'b1;
    sdi = ~sdi;
    // idle gap well above the minimum spacing between frames
    #60;
  endtask

  // bare select pulse with no clock edges
  task automatic strobe();
    #7 csN = 1'b0;
    #20 csN = 1'b1;
    #60;
  endtask
endmodule

// File: wiper_log_taper_tb.sv
// self-checking bench for the dual wiper command logic
`timescale 1ns/100ps
module wiper_log_taper_tb;
  import potentiometer_pkg::*;
  localparam logic [15:0] TOL = 16'hA40F; // arbitrary factory value
  logic                  ref_clk, rst_n, restoreStrobeN, sclk, csN, sdi, sdo;
  logic                  clkEnable;
  logic                  readPowerActive, tolerancePositive;
  logic [TAP_COUNT-1:0]  tapSwitch1, tapSwitch2;
  logic [9:0]            wiper1Value, wiper2Value;
  logic [6:0]            tolerancePercent;
  logic [7:0]            toleranceFraction;
  logic [23:0]           rx;
  logic [9:0]            e1, e2;
  int                    error_cnt, check_count;

  wiper_log_taper #(.TOLERANCE_WORD(TOL)) wiper_log_taper_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .clkEnable(clkEnable), .sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo),
    .restoreStrobeN(restoreStrobeN), .tapSwitch1(tapSwitch1), .tapSwitch2(tapSwitch2),
    .wiper1Value(wiper1Value), .wiper2Value(wiper2Value), .readPowerActive(readPowerActive),
    .tolerancePositive(tolerancePositive), .tolerancePercent(tolerancePercent),
    .toleranceFraction(toleranceFraction));

  spi_host_model spi_host_model_inst (.sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo));

  always #2 ref_clk = ~ref_clk;

  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmd(input logic [23:0] f);
    spi_host_model_inst.xfer(f, 24, rx);
  endtask

  // wiper values and the single closed tap of each channel
  task automatic wipers(input logic [9:0] x1, input logic [9:0] x2);
    chk("wiper1", 24'(x1), 24'(wiper1Value));
    chk("wiper2", 24'(x2), 24'(wiper2Value));
    chk("tap1", 24'h1, 24'(tapSwitch1 === (TAP_COUNT'(1) << x1)));
    chk("tap2", 24'h1, 24'(tapSwitch2 === (TAP_COUNT'(1) << x2)));
  endtask

  task automatic resetState();
    wipers(10'h200, 10'h200);
    chk("tolSign", 24'h1, 24'(tolerancePositive));
    chk("tolInt", 24'h24, 24'(tolerancePercent));
    chk("tolFrac", 24'h0F, 24'(toleranceFraction));
  endtask

  // single up steps from zero through saturation; data bytes set to ones on purpose
  task automatic stepUp();
    cmd(24'hB00000);
    e1 = 10'h000;
    for (int k = 0; k < 12; k++)
    begin
      cmd(24'hC0FFFF);
      e1 = (e1 == 10'h000) ? 10'h001 : (e1 >= 10'h200) ? 10'h3FF : {e1[8:0], 1'b0};
      wipers(e1, 10'h200);
    end
  endtask

  task automatic stepDown();
    cmd(24'hB103FF);
    e2 = 10'h3FF;
    for (int k = 0; k < 11; k++)
    begin
      cmd(24'h41ABCD);
      e2 = e2 >> 1;
      wipers(10'h3FF, e2);
    end
  endtask

  task automatic ganged();
    cmd(24'hB00000);
    cmd(24'hB10300);
    cmd(24'hD00000);
    wipers(10'h001, 10'h3FF);
    cmd(24'h50FFFF);
    wipers(10'h000, 10'h1FF);
    spi_host_model_inst.strobe();
    wipers(10'h000, 10'h0FF);
    cmd(24'hC00000);
    spi_host_model_inst.strobe();
    wipers(10'h002, 10'h0FF);
  endtask

  // a short frame must neither execute nor replace the remembered command
  task automatic partial();
    spi_host_model_inst.xfer(24'hB00155, 12, rx);
    wipers(10'h002, 10'h0FF);
    spi_host_model_inst.strobe();
    wipers(10'h004, 10'h0FF);
  endtask

  task automatic storeMap();
    for (int a = 2; a < 16; a++)
      cmd({OP_STORE_WORD, 4'(a), 16'(a * 16'h1111) ^ 16'h5A5A});
    for (int a = 0; a < 16; a++)
    begin
      cmd({OP_READ_STORE, 4'(a), 16'h0000});
      cmd(24'h000000);
      if (a < 2)
        chk("wordWiper", 24'h000200, rx);
      else if (a < 15)
        chk("wordGeneral", {8'h00, 16'(a * 16'h1111) ^ 16'h5A5A}, rx);
      else
        chk("wordTol", {8'h00, TOL}, rx);
    end
  endtask

  task automatic restore();
    cmd(24'h200000);
    cmd(24'hB00300);
    cmd(24'h100000);
    wipers(10'h004, 10'h0FF);
    chk("readPower", 24'h1, 24'(readPowerActive));
    cmd(24'h000000);
    chk("readPower", 24'h0, 24'(readPowerActive));
    cmd(24'hB00300);
    cmd(24'hB10100);
    chk("echo", 24'h000300, rx);
    cmd(24'h800000);
    wipers(10'h004, 10'h200);
    cmd(24'hA10000);
    cmd(24'h000000);
    chk("readWiper", 24'h000200, rx);
    cmd(24'hB00300);
    cmd(24'hB10100);
    // a frozen block must not see the pin strobe at all
    @(negedge ref_clk) clkEnable = 1'b0;
    restoreStrobeN = 1'b0;
    repeat (10) @(negedge ref_clk);
    restoreStrobeN = 1'b1;
    repeat (10) @(negedge ref_clk);
    clkEnable = 1'b1;
    repeat (10) @(negedge ref_clk);
    wipers(10'h300, 10'h100);
    @(negedge ref_clk) restoreStrobeN = 1'b0;
    repeat (10) @(negedge ref_clk);
    restoreStrobeN = 1'b1;
    repeat (10) @(negedge ref_clk);
    wipers(10'h004, 10'h200);
  endtask

  // watchdog: a hang counts as a mismatch
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    $display("[ERR] watchdog expected finish seen hang");
    error_cnt++;
    wrap_up();
  end

  initial
  begin
    ref_clk        = 1'b0;
    rst_n          = 1'b0;
    restoreStrobeN = 1'b1;
    clkEnable      = 1'b1;
    error_cnt      = 0;
    check_count    = 0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk) rst_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    resetState();
    stepUp();
    stepDown();
    ganged();
    partial();
    storeMap();
    restore();
    wrap_up();
  end
endmodule
